// ---- src/pfm_fault_status.sv ----
// PWM fault masking, latched fault/reload status and fault recovery gating.
// Assumes fault pins, comparators and debug entry are asynchronous levels,
// and that reload and period-start strobes come from the PWM timebase.
//
// Contract
// - Each fault source has its own mask bit
// - Mask bits are set-only by writes
// - Mask writes only while PWM disabled
// - Mask bit 1 blocks comparator faults
// - Mask bit 0 blocks fault-0 pin
// - Comparator faults also raise system exception
// - Fault response follows recovery control register
// - One latched status flag per source
// - Unmasked fault-0 sets status bit 0
// - Masked sources never set their flag
// - Writing one clears flag, zero keeps
// - Fault flag clears only after source deasserts
// - Timer reload sets status bit 7
// - Software recovery needs clear, deassert, reload
//
// Register layout shared by mask, status and interrupt mask:
//   bit 7  reload seen (status and interrupt mask only)
//   bit 5  debug entry
//   bit 2  fault-1 pin
//   bit 1  comparator
//   bit 0  fault-0 pin
//   bits 6, 4 and 3 are reserved and always read zero
//
// Limitations: fault inputs are taken as asynchronous levels and cost two
// cycles of latency; a pulse shorter than one clock may be missed.
// Status resets to zero so software never sees a stale source at start.
`timescale 1ns/1ps
`default_nettype none
module pfm_fault_status (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [23:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        pwm_run_enable_i,
  input  wire logic        fault0_pin_i,
  input  wire logic        fault1_pin_i,
  input  wire logic        comparator_i,
  input  wire logic        debug_entry_i,
  input  wire logic        pwm_reload_i,
  input  wire logic        pwm_period_start_i,
  output logic             pwm_fault_o,
  output logic             pwm_outputs_off_o,
  output logic             sys_fault_exc_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [3:0] src_sync;
  logic       pin0_s;
  logic       cmp_s;
  logic       pin1_s;
  logic       dbg_s;

  // Only the second flop of each pair is read below
  pfm_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    ({debug_entry_i, fault1_pin_i, comparator_i, fault0_pin_i}),
    .sync_o     (src_sync)
  );

  assign pin0_s = src_sync[0];
  assign cmp_s  = src_sync[1];
  assign pin1_s = src_sync[2];
  assign dbg_s  = src_sync[3];

  // Place a level on its status/mask bit position
  function automatic logic [7:0] at_bit(input logic v, input int pos);
    logic [7:0] r;
    r = 8'h00;
    r[pos] = v;
    return r;
  endfunction

  // Full compare on purpose: a partial decode would alias neighbouring registers
  function automatic logic addr_hit(input logic [23:0] a, input logic [23:0] target);
    return a == target;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] fault_source_mask_r;
  logic [7:0] fault_source_mask_nxt;
  logic [7:0] fault_reload_status_r;
  logic [7:0] fault_reload_status_nxt;
  logic [7:0] fault_recovery_control_r;
  logic [7:0] fault_recovery_control_nxt;
  logic [7:0] irq_mask_r;
  logic [7:0] irq_mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       dbg_d_r;
  logic       dbg_d_nxt;
  pfm_pkg::pfm_state_type state_r;
  pfm_pkg::pfm_state_type state_nxt;

  logic [7:0] src_level;
  logic [7:0] src_active;
  logic [7:0] set_ev;
  logic [7:0] clr_req;
  logic [7:0] fault_only;
  logic [7:0] fault_set;
  logic [7:0] debug_rise;
  logic [7:0] reload_set;
  logic       wr_mask;
  logic       wr_stat;
  logic       wr_ctrl;
  logic       wr_imsk;
  logic       any_fault;
  logic       any_flag;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Writes to unmapped addresses match nothing and change nothing
  always_comb begin
    wr_mask = reg_wr_i && addr_hit(reg_addr_i, pfm_pkg::FAULT_SOURCE_MASK_ADDR);
    wr_stat = reg_wr_i && addr_hit(reg_addr_i, pfm_pkg::FAULT_RELOAD_STATUS_ADDR);
    wr_ctrl = reg_wr_i && addr_hit(reg_addr_i, pfm_pkg::FAULT_RECOVERY_CTRL_ADDR);
    wr_imsk = reg_wr_i && addr_hit(reg_addr_i, pfm_pkg::FAULT_IRQ_MASK_ADDR);
  end

  // ----------------------------------------------------------------
  // Source gating
  // ----------------------------------------------------------------
  always_comb begin
    // Raw source levels in register layout
    src_level = at_bit(pin0_s, pfm_pkg::PIN0_BIT) | at_bit(cmp_s, pfm_pkg::CMP_BIT)
              | at_bit(pin1_s, pfm_pkg::PIN1_BIT) | at_bit(dbg_s, pfm_pkg::DEBUG_BIT);
    // A set mask bit blocks its source
    src_active = src_level & ~fault_source_mask_r;
    any_fault  = |src_active;
    any_flag   = |(fault_reload_status_r & pfm_pkg::MASK_IMPL);
  end

  // ----------------------------------------------------------------
  // Mask, control and interrupt mask
  // ----------------------------------------------------------------
  always_comb begin
    fault_source_mask_nxt      = fault_source_mask_r;
    fault_recovery_control_nxt = fault_recovery_control_r;
    irq_mask_nxt               = irq_mask_r;
    // Set-only so a stray write can never unmask a source
    // Set-only, and frozen while the PWM runs
    if (wr_mask && !pwm_run_enable_i) begin
      fault_source_mask_nxt = fault_source_mask_r | (reg_wdata_i & pfm_pkg::MASK_IMPL);
    end
    if (wr_ctrl) begin
      fault_recovery_control_nxt = reg_wdata_i & pfm_pkg::CTRL_IMPL;
    end
    if (wr_imsk) begin
      irq_mask_nxt = reg_wdata_i & pfm_pkg::STATUS_IMPL;
    end
    if (!rst_b_i) begin
      fault_source_mask_nxt      = pfm_pkg::MASK_RESET;
      fault_recovery_control_nxt = pfm_pkg::CTRL_RESET;
      irq_mask_nxt               = pfm_pkg::STAT_RESET;
    end
  end

  always_ff @(posedge core_clk_i) begin
    fault_source_mask_r      <= fault_source_mask_nxt;
    fault_recovery_control_r <= fault_recovery_control_nxt;
    irq_mask_r               <= irq_mask_nxt;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_comb begin
    dbg_d_nxt = rst_b_i ? dbg_s : 1'b0;
    // Pin and comparator flags follow the unmasked level
    fault_only = pfm_pkg::MASK_IMPL & ~at_bit(1'b1, pfm_pkg::DEBUG_BIT);
    fault_set  = src_active & fault_only;
    // Debug flag latches on entry, not on the level
    debug_rise = at_bit(src_active[pfm_pkg::DEBUG_BIT] && !dbg_d_r, pfm_pkg::DEBUG_BIT);
    reload_set = at_bit(pwm_reload_i, pfm_pkg::RELOAD_BIT);
    set_ev     = fault_set | debug_rise | reload_set;
    // Fault flags refuse clearing while their source still asserts
    clr_req = wr_stat ? (reg_wdata_i & pfm_pkg::STATUS_IMPL) : 8'h00;
    clr_req = clr_req & ~(src_level & fault_only);
    // Set wins over a simultaneous clear, so no event is lost
    fault_reload_status_nxt = ((fault_reload_status_r & ~clr_req) | set_ev) & pfm_pkg::STATUS_IMPL;
    if (!rst_b_i) begin
      fault_reload_status_nxt = pfm_pkg::STAT_RESET;
    end
  end

  always_ff @(posedge core_clk_i) begin
    fault_reload_status_r <= fault_reload_status_nxt;
    dbg_d_r               <= dbg_d_nxt;
  end

  // ----------------------------------------------------------------
  // Fault recovery
  // ----------------------------------------------------------------
  // Automatic recovery waits for a new period; software recovery instead
  // waits for all fault flags cleared and a reload
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Any unmasked source takes the outputs off at the next edge
      pfm_pkg::PFM_RUN: begin
        if (any_fault) begin
          state_nxt = pfm_pkg::PFM_FAULTED;
        end
      end
      // Stay off for as long as any source still asserts
      pfm_pkg::PFM_FAULTED: begin
        if (!any_fault) begin
          state_nxt = pfm_pkg::PFM_WAIT_RL;
        end
      end
      // Sources quiet; the recovery mode picks the restart event
      pfm_pkg::PFM_WAIT_RL: begin
        if (any_fault) begin
          state_nxt = pfm_pkg::PFM_FAULTED;
        end else if (fault_recovery_control_r[pfm_pkg::SW_RECOV_BIT]) begin
          if (!any_flag && pwm_reload_i) begin
            state_nxt = pfm_pkg::PFM_RUN;
          end
        end else if (pwm_period_start_i) begin
          state_nxt = pfm_pkg::PFM_RUN;
        end
      end
      // An illegal code restarts; a live source re-enters FAULTED next edge
      default: state_nxt = pfm_pkg::PFM_RUN;
    endcase
    if (!rst_b_i) begin
      state_nxt = pfm_pkg::PFM_RUN;
    end
  end

  always_ff @(posedge core_clk_i) begin
    state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    // Data stands for one cycle only; idle cycles read zero
    if (reg_rd_i) begin
      if (addr_hit(reg_addr_i, pfm_pkg::FAULT_SOURCE_MASK_ADDR)) begin
        rdata_nxt = fault_source_mask_r;
      end else if (addr_hit(reg_addr_i, pfm_pkg::FAULT_RELOAD_STATUS_ADDR)) begin
        rdata_nxt = fault_reload_status_r;
      end else if (addr_hit(reg_addr_i, pfm_pkg::FAULT_RECOVERY_CTRL_ADDR)) begin
        rdata_nxt = fault_recovery_control_r;
      end else if (addr_hit(reg_addr_i, pfm_pkg::FAULT_IRQ_MASK_ADDR)) begin
        rdata_nxt = irq_mask_r;
      end
    end
    if (!rst_b_i) begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge core_clk_i) begin
    rdata_r <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o       = rdata_r;
  assign pwm_fault_o       = any_fault;
  assign pwm_outputs_off_o = (state_r != pfm_pkg::PFM_RUN);
  // Comparator fault reaches the processor exception
  assign sys_fault_exc_o   = src_active[pfm_pkg::CMP_BIT];
  // Level interrupt: stays high until software clears the status bit
  assign irq_o             = |(fault_reload_status_r & irq_mask_r);

endmodule
`default_nettype wire

// ---- include/pfm_pkg.sv ----
// Package for the PWM fault mask and fault/reload status block.
// Assumes a single system clock domain and an 8-bit register port.
package pfm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [23:0] FAULT_SOURCE_MASK_ADDR   = 24'hffe384;
  localparam logic [23:0] FAULT_RELOAD_STATUS_ADDR = 24'hffe385;
  localparam logic [23:0] FAULT_RECOVERY_CTRL_ADDR = 24'hffe388;
  localparam logic [23:0] FAULT_IRQ_MASK_ADDR      = 24'hffe38c;

  // ----------------------------------------------------------------
  // Field positions (shared by mask and status; SW_RECOV_BIT is in recovery control)
  // ----------------------------------------------------------------
  localparam int PIN0_BIT    = 0;
  localparam int CMP_BIT     = 1;
  localparam int PIN1_BIT    = 2;
  localparam int DEBUG_BIT   = 5;
  localparam int RELOAD_BIT  = 7;
  localparam int SW_RECOV_BIT = 6;

  // Writable / readable bit sets
  localparam logic [7:0] MASK_IMPL   = 8'h27;
  localparam logic [7:0] STATUS_IMPL = 8'ha7;
  localparam logic [7:0] CTRL_IMPL   = 8'h7f;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] STAT_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Recovery state machine
  typedef enum logic [2:0] {
    PFM_RUN     = 3'h1,
    PFM_FAULTED = 3'h2,
    PFM_WAIT_RL = 3'h4
  } pfm_state_type;

endpackage

// ---- src/pfm_sync.sv ----
// Two-flop synchroniser bank for asynchronous fault inputs.
// Assumes the destination runs on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pfm_sync (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [3:0] async_i,
  output logic      [3:0] sync_o
);

  logic [3:0] meta_r;
  logic [3:0] meta_nxt;
  logic [3:0] sync_r;
  logic [3:0] sync_nxt;

  always_comb begin
    meta_nxt = rst_b_i ? async_i : 4'h0;
    sync_nxt = rst_b_i ? meta_r : 4'h0;
  end

  always_ff @(posedge core_clk_i) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_o = sync_r;

endmodule
`default_nettype wire

// ---- sim/pfm_fault_status_chk.sv ----
// Concurrent checks for the fault mask and status block.
// Sees only top-level ports; bound into every instance below.
`timescale 1ns/1ps
`default_nettype none
module pfm_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        pwm_run_enable_i,
  input wire logic        fault0_pin_i,
  input wire logic        comparator_i,
  input wire logic        pwm_reload_i,
  input wire logic        pwm_fault_o,
  input wire logic        pwm_outputs_off_o,
  input wire logic        sys_fault_exc_o
);
  logic [7:0] msk_r, msk_nxt;
  logic [1:0] age_r, age_nxt;
  wire logic  rd_m = reg_rd_i && reg_addr_i == pfm_pkg::FAULT_SOURCE_MASK_ADDR;
  wire logic  rd_s = reg_rd_i && reg_addr_i == pfm_pkg::FAULT_RELOAD_STATUS_ADDR;
  wire logic  wr_m = reg_wr_i && reg_addr_i == pfm_pkg::FAULT_SOURCE_MASK_ADDR;
  // Shadow mask; age keeps synchroniser checks off until it has refilled
  always_comb begin
    msk_nxt = msk_r;
    if (wr_m && !pwm_run_enable_i) begin
      msk_nxt = msk_r | (reg_wdata_i & pfm_pkg::MASK_IMPL);
    end
    age_nxt = age_r[1] ? age_r : age_r + 2'h1;
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      msk_r <= 8'h00;
      age_r <= 2'h0;
    end else begin
      msk_r <= msk_nxt;
      age_r <= age_nxt;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_mask_readback: assert property (rd_m |=> reg_rdata_o == $past(msk_r))
    else $error("mask readback wrong");
  a_stat_rsvd: assert property (rd_s |=> (reg_rdata_o & 8'h58) == 8'h00)
    else $error("status reserved bits not zero");
  a_pin0_fault: assert property (age_r[1] && $past(fault0_pin_i, 2) && !msk_r[0] |-> pwm_fault_o)
    else $error("unmasked fault pin gave no fault");
  a_cmp_fault: assert property (age_r[1] && $past(comparator_i, 2) && !msk_r[1]
    |-> sys_fault_exc_o && pwm_fault_o)
    else $error("unmasked comparator gave no fault");
  a_exc_cause: assert property (sys_fault_exc_o |-> pwm_fault_o && !msk_r[1])
    else $error("exception without unmasked comparator");
  a_all_masked: assert property (msk_r == pfm_pkg::MASK_IMPL |-> !pwm_fault_o)
    else $error("fault while all sources masked");
  a_fault_off: assert property (pwm_fault_o |=> pwm_outputs_off_o)
    else $error("outputs not turned off after fault");
  a_reload_flag: assert property (pwm_reload_i ##1 !reg_wr_i ##1 rd_s |=> reg_rdata_o[7])
    else $error("reload flag not set");
  c_fault: cover property (pwm_fault_o && pwm_outputs_off_o);
  c_refused: cover property (wr_m && pwm_run_enable_i);
  c_reload: cover property (pwm_reload_i ##2 rd_s);
endmodule
bind pfm_fault_status pfm_chk u_chk (
  .core_clk_i        (core_clk_i),
  .rst_b_i           (rst_b_i),
  .reg_addr_i        (reg_addr_i),
  .reg_wdata_i       (reg_wdata_i),
  .reg_wr_i          (reg_wr_i),
  .reg_rd_i          (reg_rd_i),
  .reg_rdata_o       (reg_rdata_o),
  .pwm_run_enable_i  (pwm_run_enable_i),
  .fault0_pin_i      (fault0_pin_i),
  .comparator_i      (comparator_i),
  .pwm_reload_i      (pwm_reload_i),
  .pwm_fault_o       (pwm_fault_o),
  .pwm_outputs_off_o (pwm_outputs_off_o),
  .sys_fault_exc_o   (sys_fault_exc_o)
);
`default_nettype wire

// ---- sim/pfm_src.sv ----
// Far-side model: fault pins, comparator and debug entry as levels.
// Levels follow the bench request on the falling edge, away from sampling.
`timescale 1ns/1ps
`default_nettype none
module pfm_src (
  input  wire logic       core_clk_i,
  input  wire logic [3:0] want_i,
  output var logic  [3:0] lvl_o
);
  initial lvl_o = 4'h0;
  always @(negedge core_clk_i) begin
    lvl_o <= want_i;
  end
endmodule
`default_nettype wire

// ---- sim/tb_pwm_fault_mask_status.sv ----
// Self-checking bench for the fault mask and fault/reload status block.
// Partner model supplies fault levels; reads are scored from a queue.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_fault_mask_status;
  localparam logic [23:0] MA = pfm_pkg::FAULT_SOURCE_MASK_ADDR;
  localparam logic [23:0] SA = pfm_pkg::FAULT_RELOAD_STATUS_ADDR;
  localparam logic [23:0] IA = pfm_pkg::FAULT_IRQ_MASK_ADDR;
  localparam logic [23:0] CA = pfm_pkg::FAULT_RECOVERY_CTRL_ADDR;
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        run = 1'b0, rld = 1'b0, per = 1'b0, pend = 1'b0;
  logic        fault, off, exc, irq;
  logic [23:0] addr = 24'h0;
  logic [7:0]  wdat = 8'h0, rdat, mskv;
  logic [3:0]  want = 4'h0, lvl;
  logic [7:0]  expq[$];
  int          err_total = 0, num_checks = 0;
  initial forever #12.5 core_clk_i = ~core_clk_i;
  pfm_src SRC (.core_clk_i(core_clk_i), .want_i(want), .lvl_o(lvl));
  pfm_fault_status DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .pwm_run_enable_i(run), .fault0_pin_i(lvl[0]), .comparator_i(lvl[1]),
    .fault1_pin_i(lvl[2]), .debug_entry_i(lvl[3]), .pwm_reload_i(rld),
    .pwm_period_start_i(per), .pwm_fault_o(fault), .pwm_outputs_off_o(off),
    .sys_fault_exc_o(exc), .irq_o(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [23:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= d;
    @(posedge core_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdx(input logic [23:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Read answers arrive one cycle after the strobe; oldest note first
  always @(posedge core_clk_i) begin
    if (pend) begin
      chk(rdat, expq.pop_front());
    end
    pend <= rd;
  end
  initial begin
    #100us;
    err_total++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2b5da2a0));
    hold(2);
    rst_b_i <= 1'b1;
    rdx(MA, 8'h00);
    rdx(SA, 8'h00);
    rdx(24'hffe386, 8'h00);
    want <= 4'h1;
    hold(4);
    chk({6'h0, exc, fault}, 8'h01);
    acc(1'b1, SA, 8'h01);
    rdx(SA, 8'h01);
    want <= 4'h0;
    hold(4);
    chk({7'h0, off}, 8'h01);
    per <= 1'b1;
    hold(1);
    per <= 1'b0;
    hold(1);
    chk({7'h0, off}, 8'h00);
    acc(1'b1, SA, 8'h00);
    rdx(SA, 8'h01);
    acc(1'b1, SA, 8'h01);
    rdx(SA, 8'h00);
    // Debug, comparator and fault-1 together, with the interrupt enabled
    acc(1'b1, IA, 8'h26);
    want <= 4'he;
    hold(4);
    chk({5'h0, irq, exc, fault}, 8'h07);
    want <= 4'h0;
    hold(4);
    rdx(SA, 8'h26);
    acc(1'b1, SA, 8'h26);
    rld <= 1'b1;
    hold(1);
    rld <= 1'b0;
    rdx(SA, 8'h80);
    chk({7'h0, irq}, 8'h00);
    acc(1'b1, IA, 8'h80);
    hold(1);
    chk({7'h0, irq}, 8'h01);
    acc(1'b1, SA, 8'h80);
    hold(1);
    chk({7'h0, irq}, 8'h00);
    // Software recovery: period starts ignored, needs clear flags and a reload
    acc(1'b1, CA, 8'h40);
    rdx(CA, 8'h40);
    want <= 4'h1;
    hold(4);
    want <= 4'h0;
    hold(4);
    rld <= 1'b1;
    hold(1);
    rld <= 1'b0;
    hold(1);
    chk({7'h0, off}, 8'h01);
    acc(1'b1, SA, 8'h81);
    per <= 1'b1;
    hold(1);
    per <= 1'b0;
    hold(1);
    chk({7'h0, off}, 8'h01);
    rld <= 1'b1;
    hold(1);
    rld <= 1'b0;
    hold(1);
    chk({7'h0, off}, 8'h00);
    acc(1'b1, SA, 8'h80);
    // Mask is set-only and frozen while the PWM runs
    run <= 1'b1;
    mskv = (8'($urandom) & pfm_pkg::MASK_IMPL) | 8'h01;
    acc(1'b1, MA, mskv);
    run <= 1'b0;
    rdx(MA, 8'h00);
    acc(1'b1, MA, 8'h01);
    acc(1'b1, MA, 8'h02);
    rdx(MA, 8'h03);
    want <= 4'h1;
    hold(4);
    chk({7'h0, fault}, 8'h00);
    acc(1'b1, MA, 8'h24);
    want <= 4'hf;
    hold(4);
    chk({6'h0, exc, fault}, 8'h00);
    rdx(SA, 8'h00);
    rdx(MA, 8'h27);
    hold(2);
    finish_test();
  end
endmodule
`default_nettype wire
